/* src/psi_clk_activity.sv */
// Clock activity detector: flags a monitored clock that toggles within
// a fixed window of system clock cycles.
// Assumes the monitored clock is far slower than half the system clock
// and toggles at least once per window; faster clocks can alias and then
// show as idle.
`timescale 1ns/1ps
module psi_clk_activity
    import psi_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic clk_sig_in,
    output logic seen_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sync3;
        logic [7:0] cnt;
        logic edge_seen;
        logic seen;
    } psi_act_s;

    psi_act_s s_q;
    psi_act_s s_d;

    // Window count and edge capture; first sync stage feeds only stage two
    always_comb begin
        s_d = s_q;
        s_d.sync1 = clk_sig_in;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        s_d.seen = 1'b0;
        if (s_q.cnt == ACT_WINDOW_LAST) begin
            s_d.cnt = 8'h00;
            s_d.seen = s_q.edge_seen | (s_q.sync2 ^ s_q.sync3); // [RULE23]
            s_d.edge_seen = 1'b0;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
            s_d.edge_seen = s_q.edge_seen | (s_q.sync2 ^ s_q.sync3);
        end
    end

    // Register the state
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign seen_out = s_q.seen;

endmodule

/* src/psi_pkg.sv */
// Shared constants for the per-port status, interrupt summary and pin
// polarity block.
// Assumes a 16-bit register port with byte addresses as printed and a
// single 25 MHz system clock.
package psi_pkg;

    // ------------------------------------------------------------------
    // Register port geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_TX_POL = 8'h4A;
    localparam logic [7:0] OFS_RX_POL = 8'h4C;
    localparam logic [7:0] OFS_SUMMARY = 8'h50;
    localparam logic [7:0] OFS_LIVE = 8'h52;
    localparam logic [7:0] OFS_LATCHED = 8'h54;
    localparam logic [7:0] OFS_IRQ_EN = 8'h56;
    localparam logic [7:0] OFS_PORT_CTRL = 8'h58;

    // ------------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] TX_POL_MASK = 16'h0007;
    localparam logic [15:0] RX_POL_MASK = 16'h76DE;
    localparam logic [15:0] LATCHED_MASK = 16'h00C7;
    localparam logic [15:0] IRQ_EN_MASK = 16'h0007;
    localparam logic [15:0] POL_RESET = 16'h0000;
    localparam logic [2:0] IRQ_EN_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // Transmit polarity register
    localparam int TXP_LINE_CLOCK = 2;
    localparam int TXP_CLOCK_OUT = 1;
    localparam int TXP_CLOCK_IN = 0;
    // Receive polarity register
    localparam int RXP_PAYLOAD_DATA = 14;
    localparam int RXP_OH_ENABLE_IN = 13;
    localparam int RXP_FRAME_START_OUT = 12;
    localparam int RXP_OH_SERIAL = 10;
    localparam int RXP_OH_FRAME_START = 9;
    localparam int RXP_OH_DATA = 7;
    localparam int RXP_OH_CLOCK = 6;
    localparam int RXP_NEG_RAIL = 4;
    localparam int RXP_POS_RAIL = 3;
    localparam int RXP_LINE_CLOCK = 2;
    localparam int RXP_CLOCK_OUT = 1;
    // Summary, status and latched registers
    localparam int SUM_PORT_STATUS = 9;
    localparam int ST_DRIVER_OVERLOAD = 2;
    localparam int ST_LOCK_LOST = 1;
    localparam int ST_PERF_DONE = 0;
    localparam int LAT_RX_CLOCK_SEEN = 7;
    localparam int LAT_TX_CLOCK_SEEN = 6;
    // Port control register
    localparam int CTL_GLOBAL_IRQ_EN = 0;
    localparam int CTL_PERF_REQUEST = 1;

    // ------------------------------------------------------------------
    // Pin vector layout
    // ------------------------------------------------------------------
    localparam int N_IN = 6;
    localparam int IN_TX_LINE_CLK = 0;
    localparam int IN_TX_CLK = 1;
    localparam int IN_RX_OH_EN = 2;
    localparam int IN_RX_NEG = 3;
    localparam int IN_RX_POS = 4;
    localparam int IN_RX_LINE_CLK = 5;
    localparam int N_OUT = 8;
    localparam int OUT_TX_CLK = 0;
    localparam int OUT_RX_PAYLOAD = 1;
    localparam int OUT_RX_FRAME_START = 2;
    localparam int OUT_RX_OH_SERIAL = 3;
    localparam int OUT_RX_OH_FRAME_START = 4;
    localparam int OUT_RX_OH_DATA = 5;
    localparam int OUT_RX_OH_CLK = 6;
    localparam int OUT_RX_CLK = 7;
    localparam int N_PERF = 4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_NS = 40;
    localparam int ACT_WINDOW_NS = 10240;
    localparam int ACT_WINDOW_CYC = ACT_WINDOW_NS / SYS_CLK_NS;
    localparam logic [7:0] ACT_WINDOW_LAST = 8'(ACT_WINDOW_CYC - 1);

endpackage

/* src/psi_port_status.sv */
// Per-port pin polarity control, port status/latched/enable registers and
// the port interrupt summary.
// Assumes sub-block summary inputs are already masked by their own enables
// and all pins are synchronous to sys_clk_in except the monitored clocks.
`timescale 1ns/1ps

// Function
// RULE1 - Transmit clock pins inverted by bits 2..0
// RULE2 - Receive payload, enable, frame start inverted
// RULE3 - Overhead serial and frame start inverted
// RULE4 - Overhead data and clock pins inverted
// RULE5 - Rail and line clock inputs inverted
// RULE6 - Receive clock out inverted; invert bits reset zero
// RULE7 - Summary bit 9: enabled latched port bits
// RULE8 - Summary bit 8: line code block
// RULE9 - Summary bits 7..5: trace, alarm, link
// RULE10 - Summary bits 4, 3: bit test, FIFOs
// RULE11 - Summary bits 2..0: cell, convergence, framer
// RULE12 - Interrupt pin needs summary and global enable
// RULE13 - Live bit 2 shows driver overload
// RULE14 - Live bit 1 shows lock lost
// RULE15 - Live bit 0 ANDs active update statuses
// RULE16 - Host holds update request until done
// RULE17 - Latched bits 7, 6 show clock activity
// RULE18 - Latched bit 2 on overload rise
// RULE19 - Latched bit 1 on lock loss rise
// RULE20 - Latched bit 0 on update done rise
// RULE21 - Enables gate latched bits, reset zero
// RULE22 - Latched bits clear on write one
// RULE23 - Clock active if edge within window
module psi_port_status
    import psi_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rd_data_out,
    input wire logic [N_IN-1:0] pins_in,
    output logic [N_IN-1:0] core_in_out,
    input wire logic [N_OUT-1:0] core_out_in,
    output logic [N_OUT-1:0] pins_out,
    input wire logic [8:0] sub_summary_in,
    input wire logic driver_overload_in,
    input wire logic rx_lock_lost_in,
    input wire logic [N_PERF-1:0] perf_status_in,
    input wire logic [N_PERF-1:0] perf_active_in,
    input wire logic recovered_clk_in,
    output logic perf_update_request_out,
    output logic irq_out
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Address match, used by both the write and the read decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // Invert mask for the pins entering the device
    function automatic logic [N_IN-1:0] in_mask(input logic [2:0] txp, input logic [15:0] rxp);
        in_mask = '0;
        in_mask[IN_TX_LINE_CLK] = txp[TXP_LINE_CLOCK];
        in_mask[IN_TX_CLK] = txp[TXP_CLOCK_IN];
        in_mask[IN_RX_OH_EN] = rxp[RXP_OH_ENABLE_IN];
        in_mask[IN_RX_NEG] = rxp[RXP_NEG_RAIL];
        in_mask[IN_RX_POS] = rxp[RXP_POS_RAIL];
        in_mask[IN_RX_LINE_CLK] = rxp[RXP_LINE_CLOCK];
    endfunction

    // Invert mask for the pins the device drives
    function automatic logic [N_OUT-1:0] out_mask(input logic [2:0] txp,
                                                  input logic [15:0] rxp);
        out_mask = '0;
        out_mask[OUT_TX_CLK] = txp[TXP_CLOCK_OUT];
        out_mask[OUT_RX_PAYLOAD] = rxp[RXP_PAYLOAD_DATA];
        out_mask[OUT_RX_FRAME_START] = rxp[RXP_FRAME_START_OUT];
        out_mask[OUT_RX_OH_SERIAL] = rxp[RXP_OH_SERIAL];
        out_mask[OUT_RX_OH_FRAME_START] = rxp[RXP_OH_FRAME_START];
        out_mask[OUT_RX_OH_DATA] = rxp[RXP_OH_DATA];
        out_mask[OUT_RX_OH_CLK] = rxp[RXP_OH_CLOCK];
        out_mask[OUT_RX_CLK] = rxp[RXP_CLOCK_OUT];
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] tx_pol;
        logic [15:0] rx_pol;
        logic [8:0] sub_sum;
        logic [2:0] live;
        logic [7:0] latched;
        logic [2:0] irq_en;
        logic glob_en;
        logic perf_req;
        logic [N_IN-1:0] core_in;
        logic [N_OUT-1:0] pin_out;
        logic irq;
        logic [DATA_W-1:0] rd_data;
    } psi_state_s;

    psi_state_s s_q;
    psi_state_s s_d;

    logic tx_clk_seen;
    logic rx_pin_seen;
    logic rx_rec_seen;
    logic [N_IN-1:0] in_inv;
    logic [N_OUT-1:0] out_inv;
    logic [2:0] live_new;
    logic [7:0] latch_set;
    logic [7:0] latch_clr;
    logic port_sum;
    logic [15:0] summary;

    // ------------------------------------------------------------------
    // Clock activity monitors
    // ------------------------------------------------------------------

    // Raw pins are watched: polarity does not change whether a clock toggles
    psi_clk_activity u_act_tx (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .clk_sig_in(pins_in[IN_TX_CLK]),
        .seen_out(tx_clk_seen)
    );

    psi_clk_activity u_act_rx_pin (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .clk_sig_in(pins_in[IN_RX_LINE_CLK]),
        .seen_out(rx_pin_seen)
    );

    // Separate monitor so no gate sits ahead of a synchroniser
    psi_clk_activity u_act_rx_rec (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .clk_sig_in(recovered_clk_in),
        .seen_out(rx_rec_seen)
    );

    // ------------------------------------------------------------------
    // Status decode
    // ------------------------------------------------------------------

    // Polarity masks from the stored invert bits
    assign in_inv = in_mask(s_q.tx_pol, s_q.rx_pol);
    assign out_inv = out_mask(s_q.tx_pol, s_q.rx_pol);

    // Live status; idle update sources count as done
    assign live_new[ST_DRIVER_OVERLOAD] = driver_overload_in; // [RULE13]
    assign live_new[ST_LOCK_LOST] = rx_lock_lost_in; // [RULE14]
    assign live_new[ST_PERF_DONE] = &(perf_status_in | ~perf_active_in); // [RULE15]

    // Latch set events: rising live edges and clock activity
    assign latch_set[2:0] = live_new & ~s_q.live; // [RULE18] [RULE19] [RULE20]
    assign latch_set[5:3] = 3'h0;
    assign latch_set[LAT_TX_CLOCK_SEEN] = tx_clk_seen; // [RULE17]
    assign latch_set[LAT_RX_CLOCK_SEEN] = rx_pin_seen | rx_rec_seen; // [RULE17]

    // Write-one-to-clear strobe
    assign latch_clr = (wr_in && hit(addr_in, OFS_LATCHED)) ?
                       (wr_data_in[7:0] & LATCHED_MASK[7:0]) : 8'h00; // [RULE22]

    // Port bit of the summary: only enabled latched bits count
    assign port_sum = |(s_q.latched[2:0] & s_q.irq_en); // [RULE7] [RULE21]
    assign summary = {6'h00, port_sum, s_q.sub_sum}; // [RULE8] [RULE9] [RULE10] [RULE11]

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Pin paths are registered so every output leaves a flop
        s_d.core_in = pins_in ^ in_inv; // [RULE1] [RULE2] [RULE5]
        s_d.pin_out = core_out_in ^ out_inv; // [RULE1] [RULE3] [RULE4] [RULE6]
        s_d.sub_sum = sub_summary_in;
        s_d.live = live_new;
        // Set wins over a clear in the same cycle
        s_d.latched = (s_q.latched & ~latch_clr) | latch_set; // [RULE22]
        s_d.irq = (|summary) & s_q.glob_en; // [RULE12]
        // Register writes
        if (wr_in) begin
            if (hit(addr_in, OFS_TX_POL)) begin
                s_d.tx_pol = wr_data_in[2:0] & TX_POL_MASK[2:0];
            end
            if (hit(addr_in, OFS_RX_POL)) begin
                s_d.rx_pol = wr_data_in & RX_POL_MASK;
            end
            if (hit(addr_in, OFS_IRQ_EN)) begin
                s_d.irq_en = wr_data_in[2:0] & IRQ_EN_MASK[2:0]; // [RULE21]
            end
            if (hit(addr_in, OFS_PORT_CTRL)) begin
                s_d.glob_en = wr_data_in[CTL_GLOBAL_IRQ_EN];
                // Host keeps this high until the done bit reads high
                s_d.perf_req = wr_data_in[CTL_PERF_REQUEST]; // [RULE16]
            end
        end
        // Read data stand for exactly one cycle; unmapped reads return zero
        s_d.rd_data = '0;
        if (rd_in) begin
            if (hit(addr_in, OFS_TX_POL)) begin
                s_d.rd_data = {13'h0000, s_q.tx_pol};
            end else if (hit(addr_in, OFS_RX_POL)) begin
                s_d.rd_data = s_q.rx_pol;
            end else if (hit(addr_in, OFS_SUMMARY)) begin
                s_d.rd_data = summary;
            end else if (hit(addr_in, OFS_LIVE)) begin
                s_d.rd_data = {13'h0000, s_q.live};
            end else if (hit(addr_in, OFS_LATCHED)) begin
                s_d.rd_data = {8'h00, s_q.latched};
            end else if (hit(addr_in, OFS_IRQ_EN)) begin
                s_d.rd_data = {13'h0000, s_q.irq_en};
            end else if (hit(addr_in, OFS_PORT_CTRL)) begin
                s_d.rd_data = {14'h0000, s_q.perf_req, s_q.glob_en};
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            s_q <= '0;
            s_q.tx_pol <= POL_RESET[2:0]; // [RULE6]
            s_q.rx_pol <= POL_RESET; // [RULE6]
            s_q.irq_en <= IRQ_EN_RESET; // [RULE21]
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state flops
    assign rd_data_out = s_q.rd_data;
    assign core_in_out = s_q.core_in;
    assign pins_out = s_q.pin_out;
    assign perf_update_request_out = s_q.perf_req;
    assign irq_out = s_q.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    chk_tx_clock_pol: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE1]
        !$past(rst_in) |-> pins_out[OUT_TX_CLK] ==
            ($past(core_out_in[OUT_TX_CLK]) ^ $past(s_q.tx_pol[TXP_CLOCK_OUT])))
        else $error("tx clock out polarity wrong");

    chk_rx_payload_pol: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE2]
        !$past(rst_in) |-> pins_out[OUT_RX_PAYLOAD] ==
            ($past(core_out_in[OUT_RX_PAYLOAD]) ^ $past(s_q.rx_pol[RXP_PAYLOAD_DATA])))
        else $error("rx payload polarity wrong");

    chk_rx_rail_pol: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE5]
        !$past(rst_in) |-> core_in_out[IN_RX_POS] ==
            ($past(pins_in[IN_RX_POS]) ^ $past(s_q.rx_pol[RXP_POS_RAIL])))
        else $error("rx positive rail polarity wrong");

    chk_pol_reset_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE6]
        $past(rst_in) |-> (s_q.tx_pol == 3'h0) && (s_q.rx_pol == 16'h0000))
        else $error("invert bits not zero after reset");

    chk_irq_gating: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE12]
        !$past(rst_in) |-> irq_out == ($past(|summary) && $past(s_q.glob_en)))
        else $error("interrupt pin not gated by summary and global enable");

    chk_overload_live: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE13]
        !$past(rst_in) |-> s_q.live[ST_DRIVER_OVERLOAD] == $past(driver_overload_in))
        else $error("overload live bit does not follow input");

    chk_overload_latch: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE18]
        $rose(s_q.live[ST_DRIVER_OVERLOAD]) |-> s_q.latched[ST_DRIVER_OVERLOAD])
        else $error("overload rise not latched");

    chk_lock_latch: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE19]
        $rose(s_q.live[ST_LOCK_LOST]) |-> s_q.latched[ST_LOCK_LOST])
        else $error("lock loss rise not latched");

    chk_latch_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE22]
        s_q.latched[ST_PERF_DONE] && !(wr_in && hit(addr_in, OFS_LATCHED)
            && wr_data_in[ST_PERF_DONE]) |=> s_q.latched[ST_PERF_DONE])
        else $error("latched bit dropped without a clear");

    chk_port_summary: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE7]
        s_q.latched[ST_LOCK_LOST] && s_q.irq_en[ST_LOCK_LOST] && s_q.glob_en
            |=> irq_out)
        else $error("enabled latched bit did not raise interrupt");

    chk_read_slot: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !$past(rd_in) |-> rd_data_out == 16'h0000)
        else $error("read data outside its slot");

    // Overhead pins: a wrong bit index here would only show on a board
    chk_oh_clock_pol: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE4]
        !$past(rst_in) |-> pins_out[OUT_RX_OH_CLK] ==
            ($past(core_out_in[OUT_RX_OH_CLK]) ^ $past(s_q.rx_pol[RXP_OH_CLOCK])))
        else $error("rx overhead clock polarity wrong");

    chk_oh_serial_pol: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE3]
        !$past(rst_in) |-> pins_out[OUT_RX_OH_SERIAL] ==
            ($past(core_out_in[OUT_RX_OH_SERIAL]) ^ $past(s_q.rx_pol[RXP_OH_SERIAL])))
        else $error("rx overhead serial polarity wrong");

    // Live and latched status
    chk_lock_live: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE14]
        !$past(rst_in)
            |-> s_q.live[ST_LOCK_LOST] == $past(rx_lock_lost_in))
        else $error("lock lost live bit wrong");

    chk_perf_live: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE15]
        !$past(rst_in)
            |-> s_q.live[ST_PERF_DONE] == $past(&(perf_status_in | ~perf_active_in)))
        else $error("update done bit wrong");

    chk_perf_latch: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE20]
        $rose(s_q.live[ST_PERF_DONE])
            |-> s_q.latched[ST_PERF_DONE])
        else $error("update done rise not latched");

    chk_tx_clock_seen: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE17]
        tx_clk_seen
            |=> s_q.latched[LAT_TX_CLOCK_SEEN])
        else $error("tx clock activity not latched");

    chk_rx_clock_seen: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE17]
        rx_pin_seen || rx_rec_seen
            |=> s_q.latched[LAT_RX_CLOCK_SEEN])
        else $error("rx clock activity not latched");

    chk_latch_clear: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE22]
        latch_clr[ST_LOCK_LOST] && !latch_set[ST_LOCK_LOST]
            |=> !s_q.latched[ST_LOCK_LOST])
        else $error("write one did not clear latched bit");

    chk_enable_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RULE21]
        (s_q.irq_en == 3'h0) && (s_q.sub_sum == 9'h000)
            |=> !irq_out)
        else $error("interrupt with no enabled source");

endmodule

/* testbench/psi_line_model.sv */
// Far-side model: line clocks, overhead and rail data pins.
// Assumes the bench says when clocks run; they rest low otherwise.
`timescale 1ns/1ps
module psi_line_model
    import psi_pkg::*;
(
    input wire logic clk_run_in,
    input wire logic [2:0] data_in,
    output logic [N_IN-1:0] pins_out,
    output logic recovered_clk_out
);
    logic tx_line_clk = 1'b0;
    logic tx_clk = 1'b0;
    logic rx_line_clk = 1'b0;
    logic rec_clk = 1'b0;

    // Clocks unrelated to the system clock, parked low so silence is real
    always #35 tx_line_clk = clk_run_in ? ~tx_line_clk : 1'b0;
    always #45 tx_clk = clk_run_in ? ~tx_clk : 1'b0;
    always #55 rx_line_clk = clk_run_in ? ~rx_line_clk : 1'b0;
    always #65 rec_clk = clk_run_in ? ~rec_clk : 1'b0;

    // Pin vector in the block's input order
    assign pins_out = {rx_line_clk, data_in, tx_clk, tx_line_clk};
    assign recovered_clk_out = rec_clk;
endmodule

/* testbench/test_port_status_interrupt_and_pin_invert.sv */
// Self-checking bench for the port status, summary and polarity block.
// Assumes the package, the block and the line model are compiled first.
`timescale 1ns/1ps
module test_port_status_interrupt_and_pin_invert
    import psi_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic rd_pend = 1'b0;
    logic clk_run = 1'b0;
    logic drv_ovl = 1'b0;
    logic lock_lost = 1'b0;
    logic rec_clk, preq, irq;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rd_data, txv, rxv;
    logic [2:0] data = 3'h0;
    logic [N_IN-1:0] pins, core_in;
    logic [N_OUT-1:0] core_out = 8'h00;
    logic [N_OUT-1:0] pins_o;
    logic [8:0] sub = 9'h000;
    logic [N_PERF-1:0] pst = 4'h0;
    logic [N_PERF-1:0] pact = 4'hF;
    logic [15:0] exp_q[$];
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 3139;

    psi_port_status dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr),
        .wr_data_in(wdata), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data),
        .pins_in(pins), .core_in_out(core_in), .core_out_in(core_out), .pins_out(pins_o),
        .sub_summary_in(sub), .driver_overload_in(drv_ovl), .rx_lock_lost_in(lock_lost),
        .perf_status_in(pst), .perf_active_in(pact), .recovered_clk_in(rec_clk),
        .perf_update_request_out(preq), .irq_out(irq));

    psi_line_model line (.clk_run_in(clk_run), .data_in(data), .pins_out(pins),
        .recovered_clk_out(rec_clk));

    initial begin
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= d;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
    endtask

    // Expected value queued first; the monitor pairs it with the answer
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        exp_q.push_back(exp);
        @(posedge sys_clk_in);
        addr <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask

    task automatic set_src(input int i, input logic v);
        @(posedge sys_clk_in);
        case (i)
            0: pst <= {N_PERF{v}};
            1: lock_lost <= v;
            default: drv_ovl <= v;
        endcase
    endtask

    function automatic logic [N_IN-1:0] in_mask(input logic [15:0] t, input logic [15:0] r);
        return {r[2], r[3], r[4], r[13], t[0], t[2]};
    endfunction

    function automatic logic [N_OUT-1:0] out_mask(input logic [15:0] t, input logic [15:0] r);
        return {r[1], r[6], r[7], r[9], r[10], r[12], r[14], t[1]};
    endfunction

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk_in) begin
        if (rd_pend) begin
            check(rd_data, exp_q.pop_front());
        end
        rd_pend <= rd_in;
    end

    // Hang guard, well above the two thousand or so cycles the run needs
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            wrap_up();
        end
    end

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        wait_n(20);
        rst_in <= 1'b0;
        rd(OFS_TX_POL, 16'h0000);
        rd(OFS_RX_POL, 16'h0000);
        rd(OFS_IRQ_EN, 16'h0000);
        rd(OFS_LATCHED, 16'h0000);
        wr(OFS_SUMMARY, 16'hFFFF);
        rd(OFS_SUMMARY, 16'h0000);
        rd(8'h5A, 16'h0000);
        // Random polarity masks against random pin levels
        for (int i = 0; i < 12; i++) begin
            txv = 16'($random(seed));
            rxv = 16'($random(seed));
            wr(OFS_TX_POL, txv);
            wr(OFS_RX_POL, rxv);
            rd(OFS_TX_POL, txv & TX_POL_MASK);
            rd(OFS_RX_POL, rxv & RX_POL_MASK);
            data <= 3'($random(seed));
            core_out <= 8'($random(seed));
            wait_n(3);
            check(16'({1'b0, data, 2'b00} ^ core_in), 16'(in_mask(txv, rxv)));
            check(16'(pins_o ^ core_out), 16'(out_mask(txv, rxv)));
        end
        // Update request held high across the update
        wr(OFS_PORT_CTRL, 16'h0003);
        wait_n(2);
        check(16'(preq), 16'h0001);
        rd(OFS_PORT_CTRL, 16'h0003);
        for (int i = 0; i < 3; i++) begin
            set_src(i, 1'b1);
            wait_n(3);
            rd(OFS_LIVE, 16'h1 << i);
            rd(OFS_LATCHED, 16'h1 << i);
            rd(OFS_SUMMARY, 16'h0000);
            check(16'(irq), 16'h0000);
            wr(OFS_IRQ_EN, 16'h1 << i);
            wait_n(3);
            check(16'(irq), 16'h0001);
            rd(OFS_SUMMARY, 16'h0200);
            set_src(i, 1'b0);
            wr(OFS_LATCHED, ~(16'h1 << i));
            rd(OFS_LATCHED, 16'h1 << i);
            wr(OFS_LATCHED, 16'h1 << i);
            wait_n(2);
            rd(OFS_LATCHED, 16'h0000);
            check(16'(irq), 16'h0000);
        end
        wr(OFS_PORT_CTRL, 16'h0001);
        wait_n(2);
        check(16'(preq), 16'h0000);
        // Only active sources take part in the done flag
        pact <= 4'h5;
        pst <= 4'h4;
        wait_n(3);
        rd(OFS_LIVE, 16'h0000);
        pst <= 4'h5;
        wait_n(3);
        rd(OFS_LIVE, 16'h0001);
        wr(OFS_LATCHED, 16'h0007);
        for (int j = 0; j < 9; j++) begin
            sub <= 9'h001 << j;
            wait_n(3);
            rd(OFS_SUMMARY, 16'h0001 << j);
            check(16'(irq), 16'h0001);
        end
        wr(OFS_PORT_CTRL, 16'h0000);
        wait_n(3);
        check(16'(irq), 16'h0000);
        // Clock activity seen, then cleared while silent
        clk_run <= 1'b1;
        wait_n(600);
        clk_run <= 1'b0;
        wait_n(600);
        rd(OFS_LATCHED, 16'h00C0);
        wr(OFS_LATCHED, 16'h00C0);
        wait_n(600);
        rd(OFS_LATCHED, 16'h0000);
        wait_n(4);
        check(16'(exp_q.size()), 16'h0000);
        wrap_up();
    end
endmodule
